// >>> src/pthl_pkg.sv
/*
 * Constants, register layouts and helpers of the 8-bit period timer.
 * Assumes a 32-bit APB register bus and a single system clock.
 */
`default_nettype none

package pthl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [7:0] ADDR_COUNT   = 8'h00;
    localparam logic [7:0] ADDR_PERIOD  = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_MODE    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [4:0] MODE_RESET   = 5'h00;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_RUN_BIT   = 7;
    localparam int CTRL_PRE_LSB   = 4;
    localparam int CTRL_POST_LSB  = 0;
    localparam int STAT_FLAG_BIT  = 0;
    localparam int STAT_RUN_BIT   = 1;
    localparam int STAT_POST_LSB  = 4;

    ////////////////////////////////////////////////////////////////////////
    // mode classes, upper two bits of the mode field
    localparam logic [1:0] CLS_FREE    = 2'h0;
    localparam logic [1:0] CLS_ONESHOT = 2'h1;
    localparam logic [1:0] CLS_MONO    = 2'h2;

    localparam int PRESCALE_W = 7;

    typedef struct packed {
        logic       run_enable;
        logic [2:0] prescale_select;
        logic [3:0] postscale_select;
    } pthl_ctrl_t;

    localparam pthl_ctrl_t CTRL_RESET = '{1'b0, 3'h0, 4'h0};

    // which condition of the external source a mode reacts to
    typedef enum logic [2:0] {
        TRIG_NONE,
        TRIG_RISE,
        TRIG_FALL,
        TRIG_ANY,
        TRIG_LOW,
        TRIG_HIGH,
        TRIG_ALWAYS
    } pthl_trig_t;

    typedef enum logic {
        PTHL_ST_WAIT,
        PTHL_ST_RUN
    } pthl_state_t;

    // evaluates a trigger kind against the current source conditions
    function automatic logic pthl_trig_hit(input pthl_trig_t kind, input logic rise,
                                           input logic fall, input logic level);
        case (kind)
            TRIG_RISE:   pthl_trig_hit = rise;
            TRIG_FALL:   pthl_trig_hit = fall;
            TRIG_ANY:    pthl_trig_hit = rise | fall;
            TRIG_LOW:    pthl_trig_hit = ~level;
            TRIG_HIGH:   pthl_trig_hit = level;
            TRIG_ALWAYS: pthl_trig_hit = 1'b1;
            default:     pthl_trig_hit = 1'b0;
        endcase
    endfunction

    // terminal value of the prescaler for a 1:2^sel ratio
    function automatic logic [PRESCALE_W-1:0] pthl_pre_last(input logic [2:0] sel);
        pthl_pre_last = PRESCALE_W'((8'h01 << sel) - 8'h01);
    endfunction

endpackage

`default_nettype wire

// >>> src/pthl_prescaler.sv
/*
 * Prescaler: divides the system clock by 1 to 128, one-cycle tick out.
 * Assumes the clear input comes from synchronous control logic.
 */
`default_nettype none

module pthl_prescaler (
    // clock and reset
    input  wire logic       SYS_CLK_IN,
    input  wire logic       RST_IN,
    // control
    input  wire logic       CLEAR_IN,
    input  wire logic [2:0] SELECT_IN,
    // tick
    output logic            TICK_OUT
);

    logic [pthl_pkg::PRESCALE_W-1:0] pre_cnt;
    logic [pthl_pkg::PRESCALE_W-1:0] next_pre_cnt;
    wire                             at_last;

    ////////////////////////////////////////////////////////////////////////
    // counter, ratios 1:1 up to 1:128
    assign at_last      = (pre_cnt >= pthl_pkg::pthl_pre_last(SELECT_IN)); // [R11]
    assign next_pre_cnt = (CLEAR_IN | at_last) ? '0 : pre_cnt + 1'b1;
    // cleared cycle never ticks, so a restart waits one full ratio
    assign TICK_OUT     = at_last & ~CLEAR_IN;

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= next_pre_cnt;
        end
    end

endmodule

`default_nettype wire

// >>> src/pthl_top.sv
/*
 * 8-bit period timer with prescaler, postscaler, period register and
 * hardware limit control (gate, reset, start by an external source).
 * Assumes synchronous inputs on SYS_CLK_IN and an APB master.
 */
// What this block does
// R01 - count and period are 8-bit software read/write registers
// R02 - count advances by one on each prescaled timer tick
// R03 - count equal to period signals postscaler, count clears next tick
// R04 - reset clears count and loads period with all ones
// R05 - count or control write, device or external reset clear scalers
// R06 - control register write leaves count value unchanged
// R07 - gate modes hold the count while the gate is inactive
// R08 - reset modes clear the count on selected source level or edge
// R09 - free-running: match gives zero on next tick and advances postscaler
// R10 - postscaler match pulses output one tick and clears postscaler
// R11 - prescaler divides by one up to 128
// R12 - one-shot match clears run enable; restart needs enable cycled
// R13 - one-shot only meaningful with postscale selection zero
// R14 - monostable keeps run enable set, external event restarts timer
// R15 - live count and postscaled pulse go to other modules
// R16 - source keeps six ticks between edges, three ticks of level
// R17 - one-shot: tick after match clears run enable, count stops zero
// R18 - monostable: tick after match stops count zero, enable stays set
// R19 - external triggers ignored during debug freeze
// R20 - each postscaled pulse sets a sticky status flag
`default_nettype none

module pthl_top (
    // clock and reset
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    // apb slave
    input  wire logic        APB_PSEL_IN,
    input  wire logic        APB_PENABLE_IN,
    input  wire logic        APB_PWRITE_IN,
    input  wire logic [7:0]  APB_PADDR_IN,
    input  wire logic [31:0] APB_PWDATA_IN,
    output logic             APB_PREADY_OUT,
    output logic             APB_PSLVERR_OUT,
    output logic [31:0]      APB_PRDATA_OUT,
    // hardware limit source and debug
    input  wire logic        EXT_RESET_SIGNAL_IN,
    input  wire logic        DEBUG_FREEZE_IN,
    // to other peripherals
    output logic [7:0]       COUNT_OUT,
    output logic             PERIOD_EVENT_PULSE_OUT,
    output logic             TIMER_TICK_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]            count_register;
    logic [7:0]            period_register;
    pthl_pkg::pthl_ctrl_t  timer_control_reg;
    logic [4:0]            timer_control_alt;
    logic [3:0]            post_cnt;
    logic                  period_flag;
    logic                  period_event_pulse;
    logic                  ers_q;
    pthl_pkg::pthl_state_t state;
    logic [31:0]           rdata;
    logic                  rd_bad;

    logic [7:0]            next_count;
    logic [3:0]            next_post_cnt;
    logic                  next_pulse;
    pthl_pkg::pthl_ctrl_t  next_ctrl;
    pthl_pkg::pthl_state_t next_state;
    pthl_pkg::pthl_trig_t  start_kind;
    pthl_pkg::pthl_trig_t  reset_kind;
    logic [31:0]           next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire setup_rd  = APB_PSEL_IN & ~APB_PENABLE_IN & ~APB_PWRITE_IN;
    wire access    = APB_PSEL_IN & APB_PENABLE_IN;
    wire wr        = access & APB_PWRITE_IN;
    wire hit_count = (APB_PADDR_IN == pthl_pkg::ADDR_COUNT);
    wire hit_per   = (APB_PADDR_IN == pthl_pkg::ADDR_PERIOD);
    wire hit_ctrl  = (APB_PADDR_IN == pthl_pkg::ADDR_CONTROL);
    wire hit_mode  = (APB_PADDR_IN == pthl_pkg::ADDR_MODE);
    wire hit_stat  = (APB_PADDR_IN == pthl_pkg::ADDR_STATUS);
    wire hit_any   = hit_count | hit_per | hit_ctrl | hit_mode | hit_stat;
    wire wr_count  = wr & hit_count;
    wire wr_per    = wr & hit_per;
    wire wr_ctrl   = wr & hit_ctrl;
    wire wr_mode   = wr & hit_mode;
    wire wr_stat   = wr & hit_stat;

    // zero wait states; read data is captured in the setup cycle
    assign APB_PREADY_OUT  = access;
    assign APB_PSLVERR_OUT = access & (APB_PWRITE_IN ? ~hit_any : rd_bad);
    assign APB_PRDATA_OUT  = rdata;

    ////////////////////////////////////////////////////////////////////////
    // external source conditioning
    wire freeze   = DEBUG_FREEZE_IN;
    wire ers      = EXT_RESET_SIGNAL_IN;
    wire ers_rise = ers & ~ers_q & ~freeze;                     // [R19]
    wire ers_fall = ~ers & ers_q & ~freeze;                     // [R19]

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    wire [1:0] mode_cls = timer_control_alt[4:3];
    wire [2:0] mode_sub = timer_control_alt[2:0];
    wire cls_free  = (mode_cls == pthl_pkg::CLS_FREE);
    wire cls_one   = (mode_cls == pthl_pkg::CLS_ONESHOT);
    wire cls_mono  = (mode_cls == pthl_pkg::CLS_MONO);
    // class 2 rows 110/111 are level one-shots; 000,100,101 reserved
    wire mono_edge = cls_mono & (mode_sub >= 3'h1) & (mode_sub <= 3'h3);
    wire mono_lvl  = cls_mono & (mode_sub[2:1] == 2'h3);
    wire mode_ok   = cls_free | cls_one | mono_edge | mono_lvl;
    wire shot_mode = cls_one | mono_lvl;
    wire stop_mode = shot_mode | mono_edge;

    always_comb begin
        reset_kind = pthl_pkg::TRIG_NONE;
        start_kind = pthl_pkg::TRIG_NONE;
        case (mode_cls)
            pthl_pkg::CLS_FREE: begin
                case (mode_sub)
                    3'h3:    reset_kind = pthl_pkg::TRIG_ANY;
                    3'h4:    reset_kind = pthl_pkg::TRIG_RISE;
                    3'h5:    reset_kind = pthl_pkg::TRIG_FALL;
                    3'h6:    reset_kind = pthl_pkg::TRIG_LOW;
                    3'h7:    reset_kind = pthl_pkg::TRIG_HIGH;
                    default: reset_kind = pthl_pkg::TRIG_NONE;
                endcase
            end
            pthl_pkg::CLS_ONESHOT: begin
                case (mode_sub)
                    3'h0:    start_kind = pthl_pkg::TRIG_ALWAYS;
                    3'h1:    start_kind = pthl_pkg::TRIG_RISE;
                    3'h2:    start_kind = pthl_pkg::TRIG_FALL;
                    3'h3:    start_kind = pthl_pkg::TRIG_ANY;
                    3'h4:    start_kind = pthl_pkg::TRIG_RISE;
                    3'h5:    start_kind = pthl_pkg::TRIG_FALL;
                    3'h6:    start_kind = pthl_pkg::TRIG_RISE;
                    default: start_kind = pthl_pkg::TRIG_FALL;
                endcase
                case (mode_sub)
                    3'h4:    reset_kind = pthl_pkg::TRIG_RISE;
                    3'h5:    reset_kind = pthl_pkg::TRIG_FALL;
                    3'h6:    reset_kind = pthl_pkg::TRIG_LOW;
                    3'h7:    reset_kind = pthl_pkg::TRIG_HIGH;
                    default: reset_kind = pthl_pkg::TRIG_NONE;
                endcase
            end
            pthl_pkg::CLS_MONO: begin
                case (mode_sub)
                    3'h1:    start_kind = pthl_pkg::TRIG_RISE;
                    3'h2:    start_kind = pthl_pkg::TRIG_FALL;
                    3'h3:    start_kind = pthl_pkg::TRIG_ANY;
                    3'h6:    start_kind = pthl_pkg::TRIG_HIGH;
                    3'h7:    start_kind = pthl_pkg::TRIG_LOW;
                    default: start_kind = pthl_pkg::TRIG_NONE;
                endcase
                case (mode_sub)
                    3'h6:    reset_kind = pthl_pkg::TRIG_LOW;
                    3'h7:    reset_kind = pthl_pkg::TRIG_HIGH;
                    default: reset_kind = pthl_pkg::TRIG_NONE;
                endcase
            end
            default: begin
                reset_kind = pthl_pkg::TRIG_NONE;
                start_kind = pthl_pkg::TRIG_NONE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // run conditions
    wire run_en    = timer_control_reg.run_enable;
    // level triggers are masked in freeze the same way as edges
    wire ers_lvl_q = freeze ? ~reset_kind[0] : ers;
    wire hw_reset  = run_en & mode_ok &
                     pthl_pkg::pthl_trig_hit(reset_kind, ers_rise, ers_fall, ers_lvl_q);     // [R08]
    wire start_hit = run_en & pthl_pkg::pthl_trig_hit(start_kind, ers_rise, ers_fall,
                                                      freeze ? ~start_kind[0] : ers);        // [R19]
    wire gate_ok   = ~(cls_free & (mode_sub == 3'h1) & ~ers) &
                     ~(cls_free & (mode_sub == 3'h2) & ers);                                 // [R07]
    wire running   = cls_free | (state == pthl_pkg::PTHL_ST_RUN);
    wire tick;
    wire counting  = tick & run_en & mode_ok & gate_ok & ~hw_reset & running & ~wr_count;   // [R02]
    wire match     = (count_register == period_register);                                    // [R03]
    wire wrap      = counting & match;
    wire post_hit  = wrap & (post_cnt == timer_control_reg.postscale_select);                // [R10]
    // prescaler and postscaler restart points
    wire scale_clr = wr_count | wr_ctrl | hw_reset;                                          // [R05]

    pthl_prescaler u_prescaler (
        .SYS_CLK_IN (SYS_CLK_IN),
        .RST_IN     (RST_IN),
        .CLEAR_IN   (scale_clr),
        .SELECT_IN  (timer_control_reg.prescale_select),
        .TICK_OUT   (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // next values
    assign next_count = wr_count ? APB_PWDATA_IN[7:0] :                  // [R01]
                        hw_reset ? pthl_pkg::COUNT_RESET :                // [R08]
                        wrap     ? pthl_pkg::COUNT_RESET :                // [R09] [R17] [R18]
                        counting ? count_register + 8'h01 :               // [R02]
                        count_register;                                   // [R06]

    assign next_post_cnt = scale_clr ? 4'h0 :                             // [R05]
                           post_hit  ? 4'h0 :                             // [R10]
                           wrap      ? post_cnt + 4'h1 :                  // [R09]
                           post_cnt;

    // pulse stands for exactly one timer tick; one-shot uses selection 0
    assign next_pulse = counting ? post_hit :                             // [R10] [R13]
                        tick     ? 1'b0 :
                        period_event_pulse;

    // one-shot drops its enable on the wrap; monostable keeps it
    always_comb begin
        next_ctrl = timer_control_reg;
        if (wr_ctrl) begin
            next_ctrl = pthl_pkg::pthl_ctrl_t'(APB_PWDATA_IN[7:0]);
        end else if (wrap & shot_mode) begin
            next_ctrl.run_enable = 1'b0;                                  // [R12] [R17]
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            pthl_pkg::PTHL_ST_WAIT: begin
                if (start_hit & mode_ok & ~cls_free) begin
                    next_state = pthl_pkg::PTHL_ST_RUN;                   // [R14]
                end
            end
            pthl_pkg::PTHL_ST_RUN: begin
                // a dropped enable needs a fresh start trigger after re-enable
                if (~run_en | (wrap & stop_mode) | (hw_reset & shot_mode & reset_kind[2])) begin
                    next_state = pthl_pkg::PTHL_ST_WAIT;                  // [R12] [R18]
                end
            end
            default: next_state = pthl_pkg::PTHL_ST_WAIT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, captured in setup cycle
    wire [31:0] stat_word = {24'h0, post_cnt, 2'h0, running & run_en, period_flag};
    assign next_rdata = hit_count ? {24'h0, count_register} :
                        hit_per   ? {24'h0, period_register} :
                        hit_ctrl  ? {24'h0, timer_control_reg} :
                        hit_mode  ? {27'h0, timer_control_alt} :
                        hit_stat  ? stat_word : 32'h0;

    // flag set wins over a same-cycle write-one clear
    wire next_flag = post_hit | (period_flag & ~(wr_stat & APB_PWDATA_IN[pthl_pkg::STAT_FLAG_BIT]));

    ////////////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            count_register <= pthl_pkg::COUNT_RESET;                      // [R04]
            period_register <= pthl_pkg::PERIOD_RESET;                    // [R04]
            timer_control_reg <= pthl_pkg::CTRL_RESET;
            timer_control_alt <= pthl_pkg::MODE_RESET;
            post_cnt <= 4'h0;                                             // [R05]
            period_event_pulse <= 1'b0;
            period_flag <= 1'b0;
            ers_q <= 1'b0;
            state <= pthl_pkg::PTHL_ST_WAIT;
        end else begin
            count_register <= next_count;
            period_register <= wr_per ? APB_PWDATA_IN[7:0] : period_register;   // [R01]
            timer_control_reg <= next_ctrl;
            timer_control_alt <= wr_mode ? APB_PWDATA_IN[4:0] : timer_control_alt;
            post_cnt <= next_post_cnt;
            period_event_pulse <= next_pulse;
            period_flag <= next_flag;                                     // [R20]
            ers_q <= ers;
            state <= next_state;
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rdata <= 32'h0;
            rd_bad <= 1'b0;
        end else if (setup_rd) begin
            rdata <= next_rdata;
            rd_bad <= ~hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs to other peripherals
    assign COUNT_OUT              = count_register;                       // [R15]
    assign PERIOD_EVENT_PULSE_OUT = period_event_pulse;                   // [R15]
    assign TIMER_TICK_OUT         = tick;

endmodule

`default_nettype wire

// >>> tb/pthl_src_model.sv
/*
 * Model of the external limit source.
 * Assumes the bench requests levels; the timer tick paces them.
 */
`default_nettype none

module pthl_src_model (
    // clock and reset
    input  wire logic SYS_CLK_IN,
    input  wire logic RST_IN,
    // pacing and request
    input  wire logic TICK_IN,
    input  wire logic LEVEL_REQ_IN,
    // source line
    output logic      EXT_OUT
);
    ////////////////////////////////////////
    logic [2:0] since;

    // six ticks between changes also covers the three-tick level hold
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            EXT_OUT <= 1'b0;
            since   <= 3'h6;
        end else if (LEVEL_REQ_IN != EXT_OUT && since >= 3'h6) begin
            EXT_OUT <= LEVEL_REQ_IN;
            since   <= 3'h0;
        end else if (TICK_IN && since < 3'h6) begin
            since <= since + 3'h1;
        end
    end
endmodule

`default_nettype wire

// >>> tb/pthl_properties.sv
/*
 * Port-level checks of the period timer.
 * Assumes one clock domain.
 */
`default_nettype none

module pthl_properties (
    // clock and reset
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    // apb
    input  wire logic        APB_PSEL_IN,
    input  wire logic        APB_PENABLE_IN,
    input  wire logic        APB_PWRITE_IN,
    input  wire logic [7:0]  APB_PADDR_IN,
    input  wire logic [31:0] APB_PWDATA_IN,
    input  wire logic        APB_PREADY_OUT,
    input  wire logic        APB_PSLVERR_OUT,
    // timer outputs
    input  wire logic [7:0]  COUNT_OUT,
    input  wire logic        PERIOD_EVENT_PULSE_OUT,
    input  wire logic        TIMER_TICK_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    ////////////////////////////////////////
    wire logic  acc    = APB_PSEL_IN & APB_PENABLE_IN;
    wire logic  wr_cnt = acc & APB_PWRITE_IN & (APB_PADDR_IN == pthl_pkg::ADDR_COUNT);
    wire logic  wr_per = acc & APB_PWRITE_IN & (APB_PADDR_IN == pthl_pkg::ADDR_PERIOD);
    wire logic  step   = COUNT_OUT != 8'h00;
    logic [7:0] per_q;

    // period shadow, so the wrap point is known
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) per_q <= pthl_pkg::PERIOD_RESET;
        else if (wr_per) per_q <= APB_PWDATA_IN[7:0];
    end

    a_ready_access: assert property (acc |-> APB_PREADY_OUT) else $error("no pready");
    a_ready_idle: assert property (!acc |-> !APB_PREADY_OUT) else $error("stray pready");
    a_slverr_unmapped: assert property (acc && APB_PADDR_IN > pthl_pkg::ADDR_STATUS |-> APB_PSLVERR_OUT)
        else $error("no slverr");
    a_reset_clear: assert property ($past(RST_IN) |-> COUNT_OUT == pthl_pkg::COUNT_RESET
        && !PERIOD_EVENT_PULSE_OUT) else $error("count not reset");
    a_count_tick: assert property (step && COUNT_OUT == $past(COUNT_OUT) + 8'h01 && !$past(wr_cnt)
        |-> $past(TIMER_TICK_OUT)) else $error("step without tick");
    a_wrap_period: assert property (step && COUNT_OUT == $past(COUNT_OUT) + 8'h01 && !$past(wr_cnt)
        |-> $past(COUNT_OUT) != $past(per_q)) else $error("passed period");
    a_pulse_wrap: assert property ($rose(PERIOD_EVENT_PULSE_OUT) |-> $past(TIMER_TICK_OUT)
        && COUNT_OUT == 8'h00) else $error("pulse off wrap");
    a_pulse_hold: assert property (PERIOD_EVENT_PULSE_OUT && !TIMER_TICK_OUT && !acc
        |=> PERIOD_EVENT_PULSE_OUT) else $error("pulse too short");
endmodule

bind pthl_top pthl_properties u_props (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .APB_PSEL_IN(APB_PSEL_IN), .APB_PENABLE_IN(APB_PENABLE_IN),
    .APB_PWRITE_IN(APB_PWRITE_IN), .APB_PADDR_IN(APB_PADDR_IN), .APB_PWDATA_IN(APB_PWDATA_IN),
    .APB_PREADY_OUT(APB_PREADY_OUT), .APB_PSLVERR_OUT(APB_PSLVERR_OUT), .COUNT_OUT(COUNT_OUT),
    .PERIOD_EVENT_PULSE_OUT(PERIOD_EVENT_PULSE_OUT), .TIMER_TICK_OUT(TIMER_TICK_OUT));

`default_nettype wire

// >>> tb/period_timer_hw_limit_tb.sv
/*
 * Self-checking bench of the period timer.
 * Assumes design, model and checker are compiled first.
 */
`default_nettype none

module period_timer_hw_limit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, freeze = 1'b0, src_req = 1'b0, ext, pulse, tick;
    logic [7:0]  count;
    logic [2:0]  pre_t [4] = '{3'h0, 3'h1, 3'h7, 3'h0};
    logic [3:0]  post_t [4] = '{4'h0, 4'h3, 4'h0, 4'hF};
    int          n_errors = 0, n_compared = 0, cycles = 0, hi, gap;

    always #10 clk = ~clk;
    pthl_top u_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .APB_PSEL_IN(psel), .APB_PENABLE_IN(penable),
        .APB_PWRITE_IN(pwrite), .APB_PADDR_IN(paddr), .APB_PWDATA_IN(pwdata), .APB_PREADY_OUT(pready),
        .APB_PSLVERR_OUT(pslverr), .APB_PRDATA_OUT(prdata), .EXT_RESET_SIGNAL_IN(ext),
        .DEBUG_FREEZE_IN(freeze), .COUNT_OUT(count), .PERIOD_EVENT_PULSE_OUT(pulse), .TIMER_TICK_OUT(tick));
    pthl_src_model u_src (.SYS_CLK_IN(clk), .RST_IN(rst), .TICK_IN(tick), .LEVEL_REQ_IN(src_req), .EXT_OUT(ext));

    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // run takes under two thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), exp, rdat);
    endtask
    task automatic src(input logic v);
        src_req <= v;
        @(posedge clk);
        while (ext !== v) @(posedge clk);
    endtask
    task automatic setup(input logic [7:0] mode, input logic [7:0] per);
        wr(pthl_pkg::ADDR_MODE, {24'h0, mode});
        wr(pthl_pkg::ADDR_PERIOD, {24'h0, per});
        wr(pthl_pkg::ADDR_COUNT, 32'h0);
        wr(pthl_pkg::ADDR_CONTROL, 32'h80);
    endtask

    ////////////////////////////////////////
    task automatic t_regs;
        rd(pthl_pkg::ADDR_COUNT, 32'h0);
        rd(pthl_pkg::ADDR_PERIOD, 32'hFF);
        rd(pthl_pkg::ADDR_CONTROL, 32'h0);
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        cmp("unmapped write error", 32'h1, {31'h0, rerr});
        wr(pthl_pkg::ADDR_COUNT, 32'h5A);
        wr(pthl_pkg::ADDR_PERIOD, 32'h33);
        rd(pthl_pkg::ADDR_COUNT, 32'h5A);
        rd(pthl_pkg::ADDR_PERIOD, 32'h33);
        wr(pthl_pkg::ADDR_CONTROL, 32'h0F);
        rd(pthl_pkg::ADDR_COUNT, 32'h5A);
        $display("done registers");
    endtask
    task automatic t_free;
        setup(8'h00, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr(pthl_pkg::ADDR_CONTROL, {24'h0, 1'b1, pre_t[i], post_t[i]});
            while (pulse !== 1'b0) @(posedge clk);
            while (pulse !== 1'b1) @(posedge clk);
            for (hi = 0; pulse === 1'b1; hi++) @(posedge clk);
            for (gap = hi; pulse !== 1'b1; gap++) @(posedge clk);
            cmp("pulse width", 32'(1 << pre_t[i]), 32'(hi));
            cmp("pulse spacing", 32'((3 * (post_t[i] + 1)) << pre_t[i]), 32'(gap));
        end
        wr(pthl_pkg::ADDR_CONTROL, 32'h0);
        rd(pthl_pkg::ADDR_STATUS, 32'h01);
        wr(pthl_pkg::ADDR_STATUS, 32'h01);
        rd(pthl_pkg::ADDR_STATUS, 32'h00);
        $display("done free running");
    endtask
    task automatic t_oneshot;
        setup(8'h08, 8'h20);
        repeat (50) @(posedge clk);
        rd(pthl_pkg::ADDR_COUNT, 32'h0);
        rd(pthl_pkg::ADDR_CONTROL, 32'h0);
        wr(pthl_pkg::ADDR_CONTROL, 32'h80);
        repeat (2) @(posedge clk);
        apb(1'b0, pthl_pkg::ADDR_COUNT, 32'h0);
        cmp("restarted", 32'h1, {31'h0, rdat != 32'h0});
        $display("done one shot");
    endtask
    task automatic t_gate;
        src(1'b0);
        setup(8'h01, 8'hFF);
        repeat (10) @(posedge clk);
        rd(pthl_pkg::ADDR_COUNT, 32'h0);
        src(1'b1);
        src(1'b0);
        apb(1'b0, pthl_pkg::ADDR_COUNT, 32'h0);
        cmp("gate count", 32'h1, {31'h0, rdat != 32'h0});
        repeat (10) @(posedge clk);
        rd(pthl_pkg::ADDR_COUNT, rdat);
        $display("done gate");
    endtask
    task automatic t_ext_reset;
        src(1'b0);
        setup(8'h04, 8'hFF);
        repeat (20) @(posedge clk);
        freeze <= 1'b1;
        src(1'b1);
        apb(1'b0, pthl_pkg::ADDR_COUNT, 32'h0);
        cmp("frozen edge", 32'h1, {31'h0, rdat > 32'h10});
        freeze <= 1'b0;
        src(1'b0);
        src(1'b1);
        apb(1'b0, pthl_pkg::ADDR_COUNT, 32'h0);
        cmp("edge reset", 32'h1, {31'h0, rdat < 32'h0A});
        $display("done external reset");
    endtask
    task automatic t_mono;
        src(1'b0);
        setup(8'h11, 8'h08);
        repeat (10) @(posedge clk);
        rd(pthl_pkg::ADDR_COUNT, 32'h0);
        for (int i = 0; i < 2; i++) begin
            src(1'b1);
            apb(1'b0, pthl_pkg::ADDR_COUNT, 32'h0);
            cmp("started", 32'h1, {31'h0, rdat != 32'h0});
            repeat (20) @(posedge clk);
            rd(pthl_pkg::ADDR_COUNT, 32'h0);
            rd(pthl_pkg::ADDR_CONTROL, 32'h80);
            src(1'b0);
        end
        $display("done monostable");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_free();
        t_oneshot();
        t_gate();
        t_ext_reset();
        t_mono();
        tally_and_finish();
    end
endmodule

`default_nettype wire
